// ---- rtl/rpm_pkg.sv ----
// Constants for the reference, pump and pad mode control register.
// Assumes an 8-bit register port from the serial interface decoder.
package rpm_pkg;
  // Register map
  localparam logic [7:0] MODE_ADDR = 8'h70;
  localparam logic [7:0] MODE_RESET = 8'h84;
  localparam logic [1:0] RO_TOP = 2'h2;
  // Field positions in mode_control
  localparam int CHOP_HI = 5;
  localparam int CHOP_LO = 4;
  localparam int FON_BIT = 3;
  localparam int FOFF_BIT = 2;
  localparam int REF0_BIT = 1;
  localparam int EXT1_BIT = 0;
  localparam int MODE_W = 6;
  // Chop field encodings
  localparam logic [1:0] CHOP_LOW = 2'h0;
  localparam logic [1:0] CHOP_HIGH = 2'h1;
  localparam logic [1:0] CHOP_FULL = 2'h2;
  localparam logic [1:0] CHOP_HALF = 2'h3;
  // Elementary conversion count
  localparam int ELEM_FIELD_W = 2;
  localparam int ELEM_CNT_W = 3;
  // Synchronised pins: pad0, pad1, supply monitor
  localparam int SYNC_W = 3;
endpackage

// ---- rtl/rpm_chop_if.sv ----
// Link between the mode register and the chop sequencer.
// Assumes both ends share one clock and reset.
`timescale 1ns/100ps
interface rpm_chop_if;
  logic [1:0] chop_mode;
  logic [rpm_pkg::ELEM_FIELD_W-1:0] elem_field;
  logic chop_state;
  logic conv_last;
  modport ctrl (output chop_mode, output elem_field, input chop_state, input conv_last);
  modport seq (input chop_mode, input elem_field, output chop_state, output conv_last);
endinterface

// ---- rtl/rpm_chop_seq.sv ----
// Bandgap chop sequencer stepped by elementary conversions.
// Assumes busy and elementary-done come from converter logic on the same clock.
`timescale 1ns/100ps
module rpm_chop_seq #(
  parameter int CNT_W = rpm_pkg::ELEM_CNT_W
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Converter status
  input wire logic i_conv_busy,
  input wire logic i_elem_done,
  // Mode link
  rpm_chop_if.seq chop
);
  typedef struct packed {
    logic chop;
    logic half;
    logic [CNT_W-1:0] cnt;
    logic last;
  } rpm_seq_t;

  rpm_seq_t st_ff;
  rpm_seq_t nxt_st;
  logic elem_step;
  logic [CNT_W-1:0] cnt_end;

  assign elem_step = i_conv_busy && i_elem_done;
  assign cnt_end = CNT_W'((32'h1 << chop.elem_field) - 32'h1);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.last = 1'h0;
    // Phase restarts each conversion so half-rate chop is repeatable
    if (!i_conv_busy) begin
      nxt_st.half = 1'h0;
      nxt_st.cnt = {CNT_W{1'h0}};
    end else if (elem_step) begin
      nxt_st.half = !st_ff.half;
      if (st_ff.cnt == cnt_end) begin
        nxt_st.cnt = {CNT_W{1'h0}};
        nxt_st.last = 1'h1;
      end else begin
        nxt_st.cnt = st_ff.cnt + {{(CNT_W-1){1'h0}}, 1'h1};
      end
    end
    case (chop.chop_mode)
      rpm_pkg::CHOP_LOW: nxt_st.chop = 1'h0;
      rpm_pkg::CHOP_HIGH: nxt_st.chop = 1'h1;
      rpm_pkg::CHOP_FULL: begin
        if (elem_step) begin
          nxt_st.chop = !st_ff.chop;
        end
      end
      rpm_pkg::CHOP_HALF: begin
        if (elem_step && st_ff.half) begin
          nxt_st.chop = !st_ff.chop;
        end
      end
      default: nxt_st.chop = st_ff.chop;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '{default: 1'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign chop.chop_state = st_ff.chop;
  assign chop.conv_last = st_ff.last;

  sequence s_step_mode(logic [1:0] m);
    elem_step && chop.chop_mode == m;
  endsequence

  chop_forced_a: assert property (@(posedge i_clock) disable iff (i_rst)
    chop.chop_mode == rpm_pkg::CHOP_HIGH |=> st_ff.chop)
    else $error("Chop not held high");
  chop_full_a: assert property (@(posedge i_clock) disable iff (i_rst)
    s_step_mode(rpm_pkg::CHOP_FULL) |=> st_ff.chop != $past(st_ff.chop))
    else $error("Chop missed a full-rate toggle");
  chop_idle_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_conv_busy && chop.chop_mode[1] |=> $stable(st_ff.chop))
    else $error("Chop moved outside a conversion");
  // Gap stays inside one conversion, since the half phase restarts when busy drops
  chop_half_a: assert property (@(posedge i_clock) disable iff (i_rst)
    s_step_mode(rpm_pkg::CHOP_HALF)
    ##1 (i_conv_busy && !elem_step && chop.chop_mode == rpm_pkg::CHOP_HALF) [*2]
    ##1 s_step_mode(rpm_pkg::CHOP_HALF) |=> st_ff.chop != $past(st_ff.chop, 4))
    else $error("Half-rate chop wrong over two steps");
  conv_count_a: assert property (@(posedge i_clock) disable iff (i_rst)
    elem_step && st_ff.cnt == cnt_end |=> st_ff.last && st_ff.cnt == {CNT_W{1'h0}})
    else $error("Conversion end not at two to the field");
endmodule

// ---- rtl/rpm_mode_ctrl.sv ----
// What this block does
// - Bits 5:4 pick chop low, high, full, half
// - Chop toggles only during a conversion
// - Force-on turns pump on, beats force-off
// - Force-off resets set, holds pump off
// - Bit 1 routes reference out on pad0
// - Bit 0 takes external reference from pad1
// - Pad level drives only when output, unrouted
// - Elementary count is two to the field
//
// Mode control register with reference, pump and pad routing outputs.
// Assumes the serial interface decoder presents single-cycle read and write strobes.
`timescale 1ns/100ps
module rpm_mode_ctrl (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Register port from the serial interface
  input wire logic i_reg_wr_en,
  input wire logic i_reg_rd_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Converter status and configuration
  input wire logic i_conv_busy,
  input wire logic i_elem_done,
  input wire logic [rpm_pkg::ELEM_FIELD_W-1:0] i_elem_count_field,
  // Pad configuration from the pad registers
  input wire logic i_pad0_direction,
  input wire logic i_pad1_direction,
  input wire logic i_pad0_out_level,
  input wire logic i_pad1_out_level,
  // Asynchronous inputs
  input wire logic i_pump_auto_on,
  input wire logic i_pad0_in,
  input wire logic i_pad1_in,
  // Pads
  output logic o_pad0_out,
  output logic o_pad0_oe,
  output logic o_pad1_out,
  output logic o_pad1_oe,
  output logic [1:0] o_pad_in,
  // Analog controls and conversion-end pulse
  output logic o_ref_chop,
  output logic o_pump_on,
  output logic o_ref_to_pad0,
  output logic o_ext_ref_sel,
  output logic o_conv_last
);
  typedef struct packed {
    logic [rpm_pkg::MODE_W-1:0] mode;
    logic [7:0] rdata;
    logic pump;
    logic ref0;
    logic ext1;
    logic pad0_out;
    logic pad0_oe;
    logic pad1_out;
    logic pad1_oe;
    logic [rpm_pkg::SYNC_W-1:0] sync1;
    logic [rpm_pkg::SYNC_W-1:0] sync2;
  } rpm_top_t;

  localparam rpm_top_t RST_ST = '{
    mode: rpm_pkg::MODE_RESET[rpm_pkg::MODE_W-1:0],
    default: '0
  };

  rpm_top_t st_ff;
  rpm_top_t nxt_st;
  logic mode_hit;
  logic force_on;
  logic force_off;
  logic route0;
  logic ext1;

  rpm_chop_if chop_bus ();

  assign mode_hit = i_reg_addr == rpm_pkg::MODE_ADDR;
  assign force_on = st_ff.mode[rpm_pkg::FON_BIT];
  assign force_off = st_ff.mode[rpm_pkg::FOFF_BIT];
  assign route0 = st_ff.mode[rpm_pkg::REF0_BIT];
  assign ext1 = st_ff.mode[rpm_pkg::EXT1_BIT];

  assign chop_bus.chop_mode = st_ff.mode[rpm_pkg::CHOP_HI:rpm_pkg::CHOP_LO];
  assign chop_bus.elem_field = i_elem_count_field;

  rpm_chop_seq #(
    .CNT_W(rpm_pkg::ELEM_CNT_W)
  ) u_chop (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_conv_busy(i_conv_busy),
    .i_elem_done(i_elem_done),
    .chop(chop_bus.seq)
  );

  always_comb begin
    nxt_st = st_ff;
    // Pins settle through two flops before any use
    nxt_st.sync1 = {i_pump_auto_on, i_pad1_in, i_pad0_in};
    nxt_st.sync2 = st_ff.sync1;
    if (i_reg_wr_en && mode_hit) begin
      nxt_st.mode = i_reg_wdata[rpm_pkg::MODE_W-1:0];
    end
    // Read image with fixed top bits
    if (i_reg_rd_en) begin
      nxt_st.rdata = mode_hit ? {rpm_pkg::RO_TOP, st_ff.mode} : 8'h00;
    end
    // Force-on wins; neither forced follows the supply monitor
    nxt_st.pump = force_on || (!force_off && st_ff.sync2[2]);
    nxt_st.ref0 = route0;
    nxt_st.ext1 = ext1;
    // Pad drives only as output and unrouted
    nxt_st.pad0_oe = i_pad0_direction && !route0;
    nxt_st.pad1_oe = i_pad1_direction && !ext1;
    nxt_st.pad0_out = i_pad0_out_level;
    nxt_st.pad1_out = i_pad1_out_level;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_reg_rdata = st_ff.rdata;
  assign o_pad0_out = st_ff.pad0_out;
  assign o_pad0_oe = st_ff.pad0_oe;
  assign o_pad1_out = st_ff.pad1_out;
  assign o_pad1_oe = st_ff.pad1_oe;
  assign o_pad_in = st_ff.sync2[1:0];
  assign o_ref_chop = chop_bus.chop_state;
  assign o_pump_on = st_ff.pump;
  assign o_ref_to_pad0 = st_ff.ref0;
  assign o_ext_ref_sel = st_ff.ext1;
  assign o_conv_last = chop_bus.conv_last;

  sequence s_mode_write;
    i_reg_wr_en && mode_hit;
  endsequence

  sequence s_mode_read;
    i_reg_rd_en && mode_hit && !i_reg_wr_en;
  endsequence

  field_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
    s_mode_write |=> chop_bus.chop_mode == $past(i_reg_wdata[rpm_pkg::CHOP_HI:rpm_pkg::CHOP_LO]))
    else $error("Chop field not written");
  fixed_top_a: assert property (@(posedge i_clock) disable iff (i_rst)
    s_mode_read |=> o_reg_rdata == {rpm_pkg::RO_TOP, $past(st_ff.mode)})
    else $error("Mode read image wrong");
  pump_prio_a: assert property (@(posedge i_clock) disable iff (i_rst)
    s_mode_write ##0 i_reg_wdata[rpm_pkg::FON_BIT] ##1 !(i_reg_wr_en && mode_hit) |=> o_pump_on)
    else $error("Force-on did not start pump");
  pump_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !force_on && force_off |=> !o_pump_on)
    else $error("Pump on while forced off");
  ref_out_a: assert property (@(posedge i_clock) disable iff (i_rst)
    route0 |=> o_ref_to_pad0 && !o_pad0_oe)
    else $error("Reference not routed to pad0");
  ext_ref_a: assert property (@(posedge i_clock) disable iff (i_rst)
    ext1 |=> o_ext_ref_sel && !o_pad1_oe)
    else $error("External reference not selected");
  pad_drive_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_pad0_direction && !route0 |=> o_pad0_oe && o_pad0_out == $past(i_pad0_out_level))
    else $error("Pad0 not driven as output");

  // Register image checks
  mode_load_a: assert property (@(posedge i_clock) disable iff (i_rst)
    s_mode_write |=> st_ff.mode == $past(i_reg_wdata[rpm_pkg::MODE_W-1:0]))
    else $error("Mode bits not loaded");
  mode_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !(i_reg_wr_en && mode_hit) |=> $stable(st_ff.mode))
    else $error("Mode changed without a write");
  rdata_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_reg_rd_en |=> $stable(o_reg_rdata))
    else $error("Read data changed without a read");

  // Pump checks
  sequence s_pump_free;
    !force_on && !force_off;
  endsequence

  pump_force_a: assert property (@(posedge i_clock) disable iff (i_rst)
    force_on |=> o_pump_on)
    else $error("Pump off while forced on");
  pump_both_a: assert property (@(posedge i_clock) disable iff (i_rst)
    force_on && force_off |=> o_pump_on)
    else $error("Force-off beat force-on");
  pump_auto_a: assert property (@(posedge i_clock) disable iff (i_rst)
    s_pump_free |=> o_pump_on == $past(st_ff.sync2[2]))
    else $error("Pump not following supply monitor");

  // Routing and chop checks
  ref_idle_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !route0 |=> !o_ref_to_pad0)
    else $error("Reference routed while disabled");
  ext_idle_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !ext1 |=> !o_ext_ref_sel)
    else $error("External reference selected while disabled");
  chop_low_a: assert property (@(posedge i_clock) disable iff (i_rst)
    chop_bus.chop_mode == rpm_pkg::CHOP_LOW |=> !o_ref_chop)
    else $error("Chop not held low");

  // Pad checks
  pad1_drive_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_pad1_direction && !ext1 |=> o_pad1_oe && o_pad1_out == $past(i_pad1_out_level))
    else $error("Pad1 not driven as output");
  pad0_input_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_pad0_direction |=> !o_pad0_oe)
    else $error("Pad0 driven while input");
  pad1_input_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_pad1_direction |=> !o_pad1_oe)
    else $error("Pad1 driven while input");
endmodule

// ---- verification/rpm_mode_ctrl_tb.sv ----
// Self-checking bench for the mode control register block.
// Assumes single-cycle register strobes and one 50 MHz clock; bench drives on falling edges.
`timescale 1ns/100ps
`define check_eq(nm, exp, act) begin checked++; if ((act) !== (exp)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", nm, exp, act); end end
module rpm_mode_ctrl_tb;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic wr = 1'b0, rd = 1'b0, busy = 1'b0, done = 1'b0, auto_on = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [1:0] field = 2'h0, dir = 2'h0, lvl = 2'h0, pin = 2'h0, pad_in;
  logic p0_out, p0_oe, p1_out, p1_oe, chop, pump, ref0, ext1, last;
  int num_errors = 0;
  int checked = 0;
  int last_seen = 0;

  rpm_mode_ctrl u_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_reg_wr_en(wr), .i_reg_rd_en(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_conv_busy(busy), .i_elem_done(done),
    .i_elem_count_field(field), .i_pad0_direction(dir[0]), .i_pad1_direction(dir[1]),
    .i_pad0_out_level(lvl[0]), .i_pad1_out_level(lvl[1]), .i_pump_auto_on(auto_on),
    .i_pad0_in(pin[0]), .i_pad1_in(pin[1]), .o_pad0_out(p0_out), .o_pad0_oe(p0_oe),
    .o_pad1_out(p1_out), .o_pad1_oe(p1_oe), .o_pad_in(pad_in), .o_ref_chop(chop),
    .o_pump_on(pump), .o_ref_to_pad0(ref0), .o_ext_ref_sel(ext1), .o_conv_last(last)
  );

  initial begin
    forever #10 i_clock = ~i_clock;
  end

  // Counted on falling edges so a one-cycle pulse is seen exactly once
  always @(negedge i_clock) begin
    if (last === 1'b1) last_seen++;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge i_clock);
    wr = 1'b0;
    tick(2);
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_clock);
    rd = 1'b1;
    addr = a;
    @(negedge i_clock);
    rd = 1'b0;
    tick(1);
    `check_eq("rdata", exp, rdata)
  endtask

  task automatic step();
    @(negedge i_clock);
    done = 1'b1;
    @(negedge i_clock);
    done = 1'b0;
    tick(1);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge i_clock);
    num_errors++;
    print_verdict();
  end

  initial begin
    tick(5);
    i_rst = 1'b0;
    tick(1);
    reg_rd(rpm_pkg::MODE_ADDR, rpm_pkg::MODE_RESET);
    `check_eq("pump", 1'b0, pump)
    reg_rd(8'h71, 8'h00);
    reg_wr(rpm_pkg::MODE_ADDR, 8'hFF);
    reg_rd(rpm_pkg::MODE_ADDR, 8'hBF);
    dir = 2'h3;
    lvl = 2'h3;
    tick(2);
    `check_eq("pump", 1'b1, pump)
    `check_eq("ref0", 1'b1, ref0)
    `check_eq("ext1", 1'b1, ext1)
    `check_eq("oe0", 1'b0, p0_oe)
    `check_eq("oe1", 1'b0, p1_oe)
    reg_wr(rpm_pkg::MODE_ADDR, 8'h10);
    `check_eq("chop", 1'b1, chop)
    `check_eq("ref0", 1'b0, ref0)
    `check_eq("oe0", 1'b1, p0_oe)
    `check_eq("out0", 1'b1, p0_out)
    `check_eq("oe1", 1'b1, p1_oe)
    `check_eq("out1", 1'b1, p1_out)
    reg_wr(rpm_pkg::MODE_ADDR, 8'h04);
    `check_eq("pump", 1'b0, pump)
    `check_eq("chop", 1'b0, chop)
    pin = 2'h2;
    tick(4);
    `check_eq("pad_in", 2'h2, pad_in)
    field = 2'h1;
    reg_wr(rpm_pkg::MODE_ADDR, 8'h20);
    `check_eq("pump", 1'b1, pump)
    auto_on = 1'b0;
    tick(4);
    `check_eq("pump", 1'b0, pump)
    step();
    `check_eq("chop", 1'b0, chop)
    @(negedge i_clock);
    busy = 1'b1;
    step();
    `check_eq("chop", 1'b1, chop)
    step();
    `check_eq("chop", 1'b0, chop)
    `check_eq("last", 1, last_seen)
    @(negedge i_clock);
    busy = 1'b0;
    reg_wr(rpm_pkg::MODE_ADDR, 8'h30);
    @(negedge i_clock);
    busy = 1'b1;
    step();
    `check_eq("chop", 1'b0, chop)
    step();
    `check_eq("chop", 1'b1, chop)
    @(negedge i_clock);
    busy = 1'b0;
    print_verdict();
  end
endmodule
